// ==== design/ftpm_pkg.sv ====
// Constants, encodings and register map of the fan tachometer period monitor
// Functional notes
// - Channel mode bits 0/1 select analog or tach
// - Channel mode bits reset to zero: tach inputs
// - Gate 22.5 kHz reference into 8-bit counter
// - Start bit one with clear bit zero starts
// - Count from rising edge to second rise after
// - Fans measured in turn; two cycles or full
// - Completed count stored, readable, keeps updating
// - Per-fan prescaler 1, 2, 4, 8; default 2
// - Count equals reference times 60 over rpm*divisor
// - Counter saturates at 255, never wraps
// - Divisors sit in bits 7:4 of register
// - Flag failure when count exceeds low-speed limit
// - Measurement needs three rising edges
// - Fan sequence starts with analog, otherwise unsynchronised
// - Monitoring repeats until start bit cleared
package ftpm_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned REF_HZ = 22_500;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned DIV_W  = 2;

  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_CHMODE  = 8'h04;
  localparam logic [7:0] OFF_VIDDIV  = 8'h08;
  localparam logic [7:0] OFF_VALUE_A = 8'h0C;
  localparam logic [7:0] OFF_VALUE_B = 8'h10;
  localparam logic [7:0] OFF_LIMIT_A = 8'h14;
  localparam logic [7:0] OFF_LIMIT_B = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h1C;
  localparam logic [7:0] OFF_MASK    = 8'h20;

  localparam int unsigned CFG_START_BIT  = 0;
  localparam int unsigned CFG_INT_EN_BIT = 1;
  localparam int unsigned CFG_INT_CLR_BIT = 3;
  localparam int unsigned CHM_A_BIT      = 0;
  localparam int unsigned CHM_B_BIT      = 1;
  localparam int unsigned DIV_A_LSB      = 4;
  localparam int unsigned DIV_B_LSB      = 6;
  localparam int unsigned STAT_A_BIT     = 0;
  localparam int unsigned STAT_B_BIT     = 1;

  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] CFG_MASK   = 8'h0B;
  localparam logic [1:0] CHM_RST    = 2'h0;
  localparam logic [3:0] DIV_RST    = 4'h5;
  localparam logic [7:0] LIMIT_RST  = 8'hFF;
  localparam logic [1:0] FLAG_RST   = 2'h0;
  localparam logic [7:0] CNT_FULL   = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_COUNT = 2'b10
  } ftpm_state_t;

endpackage : ftpm_pkg

// ==== design/ftpm_tach_if.sv ====
// Synchronised tachometer level and rising-edge pulse between modules
interface ftpm_tach_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : ftpm_tach_if

// ==== design/ftpm_tach_sync.sv ====
// Two-stage synchroniser and rising-edge detector for one tachometer pin
module ftpm_tach_sync
(
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_pin,
  ftpm_tach_if.src   tach
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Only sync_r reads meta_r
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign tach.level = sync_r;
  assign tach.rise  = sync_r & ~prev_r;
endmodule : ftpm_tach_sync

// ==== design/ftpm_ref_gen.sv ====
// Fractional divider making the 22.5 kHz reference tick from the system clock
module ftpm_ref_gen
#(
  parameter int unsigned CLK_HZ = ftpm_pkg::CLK_HZ,
  parameter int unsigned REF_HZ = ftpm_pkg::REF_HZ
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_ref_tick
);
  localparam int unsigned ACC_W = $clog2(CLK_HZ) + 1;
  localparam logic [ACC_W-1:0] STEP = ACC_W'(REF_HZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_HZ);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_sum;

  // Phase accumulator keeps the long-run rate exact, at one clock of jitter
  assign acc_sum = acc_r + STEP;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      acc_r      <= '0;
      o_ref_tick <= 1'b0;
    end
    else if (acc_sum >= WRAP)
    begin
      acc_r      <= acc_sum - WRAP;
      o_ref_tick <= 1'b1;
    end
    else
    begin
      acc_r      <= acc_sum;
      o_ref_tick <= 1'b0;
    end
  end
endmodule : ftpm_ref_gen

// ==== design/ftpm_monitor.sv ====
// Top of the fan tachometer period monitor: APB registers, sequencer, counter
//
// Our own choices: register access over APB and the register offsets.
module ftpm_monitor
#(
  parameter int unsigned CLK_HZ = ftpm_pkg::CLK_HZ,
  parameter int unsigned REF_HZ = ftpm_pkg::REF_HZ
)
(
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [ftpm_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic [31:0]                      o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_tach_input_a,
  input  wire logic                        i_tach_input_b,
  output logic [1:0]                       o_analog_sel,
  output logic                             o_monitor_start,
  output logic                             o_irq
);

  localparam int unsigned CW = ftpm_pkg::CNT_W;
  localparam int unsigned DW = ftpm_pkg::DIV_W;

  // Register state
  logic [7:0]    config_r;
  logic [1:0]    chmode_r;
  logic [3:0]    divsel_r;
  logic [CW-1:0] value_a_r;
  logic [CW-1:0] value_b_r;
  logic [CW-1:0] limit_a_r;
  logic [CW-1:0] limit_b_r;
  logic [1:0]    status_r;
  logic [1:0]    mask_r;
  logic [31:0]   rdata_r;

  // Bus decode
  logic          setup_ph;
  logic          access_ph;
  logic          wr_en;
  logic          rd_en;
  logic          addr_hit;
  logic [31:0]   rdata_mux;

  // Measurement
  ftpm_pkg::ftpm_state_t state_r;
  ftpm_pkg::ftpm_state_t state_nxt;
  logic          fan_sel_r;
  logic          run;
  logic          run_d_r;
  logic          fan_enabled;
  logic          cur_rise;
  logic [DW-1:0] cur_div;
  logic [2:0]    pre_cnt_r;
  logic [2:0]    pre_max;
  logic          cnt_tick;
  logic [CW-1:0] cnt_r;
  logic          saturated;
  logic          meas_done;
  logic          mid_seen_r;
  logic [1:0]    fail_set;
  logic          ref_tick;

  ftpm_tach_if tach_a ();
  ftpm_tach_if tach_b ();

  ftpm_tach_sync u_sync_a
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_tach_input_a),
    .tach      (tach_a)
  );

  ftpm_tach_sync u_sync_b
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_tach_input_b),
    .tach      (tach_b)
  );

  ftpm_ref_gen
  #(
    .CLK_HZ (CLK_HZ),
    .REF_HZ (REF_HZ)
  )
  u_ref
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .o_ref_tick (ref_tick)
  );

  // APB: zero-wait slave, read data captured during the setup cycle
  assign setup_ph  = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign wr_en     = access_ph & i_pwrite;
  assign rd_en     = access_ph & ~i_pwrite;
  assign o_pready  = access_ph;
  assign o_pslverr = access_ph & ~addr_hit;
  assign o_prdata  = rdata_r;

  always_comb
  begin
    addr_hit  = 1'b1;
    rdata_mux = '0;
    unique case (i_paddr)
      ftpm_pkg::OFF_CONFIG:  rdata_mux[7:0] = config_r;
      ftpm_pkg::OFF_CHMODE:  rdata_mux[1:0] = chmode_r;
      ftpm_pkg::OFF_VIDDIV:  rdata_mux[7:4] = divsel_r;
      ftpm_pkg::OFF_VALUE_A: rdata_mux[CW-1:0] = value_a_r;
      ftpm_pkg::OFF_VALUE_B: rdata_mux[CW-1:0] = value_b_r;
      ftpm_pkg::OFF_LIMIT_A: rdata_mux[CW-1:0] = limit_a_r;
      ftpm_pkg::OFF_LIMIT_B: rdata_mux[CW-1:0] = limit_b_r;
      ftpm_pkg::OFF_STATUS:  rdata_mux[1:0] = status_r;
      ftpm_pkg::OFF_MASK:    rdata_mux[1:0] = mask_r;
      default:               addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      rdata_r <= '0;
    end
    else if (setup_ph)
    begin
      rdata_r <= rdata_mux;
    end
  end

  // Software-written control registers
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      config_r  <= ftpm_pkg::CFG_RST;
      chmode_r  <= ftpm_pkg::CHM_RST;
      divsel_r  <= ftpm_pkg::DIV_RST;
      limit_a_r <= ftpm_pkg::LIMIT_RST;
      limit_b_r <= ftpm_pkg::LIMIT_RST;
      mask_r    <= ftpm_pkg::FLAG_RST;
    end
    else if (wr_en)
    begin
      unique case (i_paddr)
        ftpm_pkg::OFF_CONFIG:  config_r  <= i_pwdata[7:0] & ftpm_pkg::CFG_MASK;
        ftpm_pkg::OFF_CHMODE:  chmode_r  <= i_pwdata[1:0];
        ftpm_pkg::OFF_VIDDIV:  divsel_r  <= i_pwdata[7:4];
        ftpm_pkg::OFF_LIMIT_A: limit_a_r <= i_pwdata[CW-1:0];
        ftpm_pkg::OFF_LIMIT_B: limit_b_r <= i_pwdata[CW-1:0];
        ftpm_pkg::OFF_MASK:    mask_r    <= i_pwdata[1:0];
        default:               mask_r    <= mask_r;
      endcase
    end
  end

  // Start needs the clear bit low; the analog sequencer sees the same strobe
  assign run             = config_r[ftpm_pkg::CFG_START_BIT]
                         & ~config_r[ftpm_pkg::CFG_INT_CLR_BIT];
  assign o_monitor_start = run;
  assign o_analog_sel    = chmode_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      run_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= run;
    end
  end

  // Current fan: a pin in analog mode is skipped by the sequencer
  assign fan_enabled = fan_sel_r ? ~chmode_r[ftpm_pkg::CHM_B_BIT]
                                 : ~chmode_r[ftpm_pkg::CHM_A_BIT];
  assign cur_rise    = fan_sel_r ? tach_b.rise : tach_a.rise;
  assign cur_div     = fan_sel_r ? divsel_r[ftpm_pkg::DIV_B_LSB-ftpm_pkg::DIV_A_LSB +: DW]
                                 : divsel_r[0 +: DW];

  // Divide by 1, 2, 4 or 8: code n counts 2^n reference ticks per step
  assign pre_max  = 3'((4'h1 << cur_div) - 4'h1);
  assign cnt_tick = ref_tick && (pre_cnt_r == pre_max);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      pre_cnt_r <= '0;
    end
    else if (state_r != ftpm_pkg::ST_COUNT || cnt_tick)
    begin
      pre_cnt_r <= '0;
    end
    else if (ref_tick)
    begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end

  assign saturated = (cnt_r == ftpm_pkg::CNT_FULL);

  // Second rise after the start rise ends the window; full scale ends it early
  assign meas_done = (state_r == ftpm_pkg::ST_COUNT)
                   && ((cur_rise && mid_seen_r) || saturated);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || state_r != ftpm_pkg::ST_COUNT)
      mid_seen_r <= 1'b0;
    else if (cur_rise)
      mid_seen_r <= 1'b1;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ftpm_pkg::ST_IDLE:
      begin
        if (run && run_d_r && fan_enabled)
        begin
          state_nxt = ftpm_pkg::ST_ARM;
        end
      end
      ftpm_pkg::ST_ARM:
      begin
        if (cur_rise)
        begin
          state_nxt = ftpm_pkg::ST_COUNT;
        end
      end
      ftpm_pkg::ST_COUNT:
      begin
        if (meas_done)
        begin
          state_nxt = ftpm_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ftpm_pkg::ST_IDLE;
      end
    endcase
    if (!run)
    begin
      state_nxt = ftpm_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_r <= ftpm_pkg::ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Fan pointer: restarts at the first fan whenever monitoring is restarted
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      fan_sel_r <= 1'b0;
    end
    else if (!run)
    begin
      fan_sel_r <= 1'b0;
    end
    else if (run_d_r && state_r == ftpm_pkg::ST_IDLE && !fan_enabled)
    begin
      fan_sel_r <= ~fan_sel_r;
    end
    else if (meas_done)
    begin
      fan_sel_r <= ~fan_sel_r;
    end
  end

  // Period counter: the start edge clears it, it never wraps past full scale
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= '0;
    end
    else if (state_r != ftpm_pkg::ST_COUNT)
    begin
      cnt_r <= '0;
    end
    else if (cnt_tick && !saturated)
    begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // Result registers hold the last completed count until the next one
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      value_a_r <= '0;
      value_b_r <= '0;
    end
    else if (meas_done && !fan_sel_r)
    begin
      value_a_r <= cnt_r;
    end
    else if (meas_done && fan_sel_r)
    begin
      value_b_r <= cnt_r;
    end
  end

  // Low-speed check only: a longer period means a slower fan
  assign fail_set[ftpm_pkg::STAT_A_BIT] = meas_done & ~fan_sel_r
                                        & (cnt_r > limit_a_r);
  assign fail_set[ftpm_pkg::STAT_B_BIT] = meas_done & fan_sel_r
                                        & (cnt_r > limit_b_r);

  // Sticky status; a read clears only the bits it returned, so a failure
  // latched between setup and access is not lost, and a set wins a clear
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      status_r <= ftpm_pkg::FLAG_RST;
    end
    else if (rd_en && i_paddr == ftpm_pkg::OFF_STATUS)
    begin
      status_r <= (status_r & ~rdata_r[1:0]) | fail_set;
    end
    else
    begin
      status_r <= status_r | fail_set;
    end
  end

  // Mask bit high hides a flag; the clear bit forces the output off
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= (|(status_r & ~mask_r))
             & config_r[ftpm_pkg::CFG_INT_EN_BIT]
             & ~config_r[ftpm_pkg::CFG_INT_CLR_BIT];
    end
  end

  // Level copies of the pins are not needed beyond edge detection here
  logic unused_levels;
  assign unused_levels = tach_a.level ^ tach_b.level;

endmodule : ftpm_monitor

// ==== testbench/ftpm_monitor_sva.sv ====
// Port-level assertions for the fan tachometer period monitor
module ftpm_monitor_sva
(
  input wire logic                        i_sys_clk,
  input wire logic                        i_rst_n,
  input wire logic                        i_psel,
  input wire logic                        i_penable,
  input wire logic                        i_pwrite,
  input wire logic [ftpm_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0]                 i_pwdata,
  input wire logic [31:0]                 o_prdata,
  input wire logic                        o_pready,
  input wire logic                        o_pslverr,
  input wire logic [1:0]                  o_analog_sel,
  input wire logic                        o_monitor_start,
  input wire logic                        o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic acc_w;
  logic cfg_w;
  logic chm_w;
  logic mapped;
  logic irq_ok_r;
  assign acc_w  = i_psel && i_penable && i_pwrite;
  assign cfg_w  = acc_w && (i_paddr == ftpm_pkg::OFF_CONFIG);
  assign chm_w  = acc_w && (i_paddr == ftpm_pkg::OFF_CHMODE);
  assign mapped = (i_paddr <= ftpm_pkg::OFF_MASK) && (i_paddr[1:0] == 2'h0);
  // Own copy of enable and clear, so a design slip there cannot hide itself
  always_ff @(posedge i_sys_clk)
    if (!i_rst_n)
      irq_ok_r <= 1'b0;
    else if (cfg_w)
      irq_ok_r <= i_pwdata[1] && !i_pwdata[3];

  a_ready_zero_wait: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready missing in access phase");
  a_no_stray_resp: assert property (!(i_psel && i_penable) |-> !o_pready && !o_pslverr)
    else $error("response outside access phase");
  a_err_unmapped: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_start_on_write: assert property (cfg_w |=> o_monitor_start ==
    ($past(i_pwdata[0]) && !$past(i_pwdata[3])))
    else $error("start output wrong after config write");
  a_start_held: assert property (!cfg_w |=> $stable(o_monitor_start))
    else $error("start output moved without config write");
  a_mode_on_write: assert property (chm_w |=> o_analog_sel == $past(i_pwdata[1:0]))
    else $error("channel mode output wrong after write");
  a_mode_held: assert property (!chm_w |=> $stable(o_analog_sel))
    else $error("channel mode output moved without write");
  a_mode_readback: assert property (i_psel && i_penable && !i_pwrite &&
    i_paddr == ftpm_pkg::OFF_CHMODE |-> o_prdata == {30'h0, o_analog_sel})
    else $error("channel mode read differs from output");
  a_irq_gated: assert property (o_irq |-> $past(irq_ok_r))
    else $error("irq high while disabled or cleared");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> o_analog_sel == 2'h0 &&
    !o_irq && !o_monitor_start)
    else $error("outputs not at reset values");

  c_irq: cover property (o_irq);
  c_start: cover property (cfg_w && i_pwdata[0]);
  c_bad_addr: cover property (i_psel && i_penable && o_pslverr);
endmodule : ftpm_monitor_sva

bind ftpm_monitor ftpm_monitor_sva i_ftpm_monitor_sva
(
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_analog_sel(o_analog_sel),
  .o_monitor_start(o_monitor_start), .o_irq(o_irq)
);

// ==== testbench/ftpm_fan_model.sv ====
// Behavioural fan tachometer: square wave of a set period, frozen when stopped
module ftpm_fan_model
(
  input  wire logic [31:0] i_period_ns,
  output logic             o_tach
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_tach = 1'b1;
  // Runs off its own time base, so edges drift against the system clock
  // An unset or zero period idles the pin instead of spinning in zero time
  always
  begin
    if (i_period_ns > 32'd1)
    begin
      #(i_period_ns / 2);
      o_tach = ~o_tach;
    end
    else
    begin
      #1;
    end
  end
endmodule : ftpm_fan_model

// ==== testbench/tb_top.sv ====
// Self-checking bench: registers, period counts, saturation and interrupt
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned REF  = 2_500_000;
  localparam int          WAIT = 7400;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, mstart, ta, tb_pin, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, per_a, per_b, held;
  logic [1:0]  asel;
  int          num_errors, n_compared, cyc, seed;
  logic [7:0]  ra [10] = '{ftpm_pkg::OFF_CONFIG, ftpm_pkg::OFF_CHMODE, ftpm_pkg::OFF_VIDDIV,
    ftpm_pkg::OFF_VALUE_A, ftpm_pkg::OFF_VALUE_B, ftpm_pkg::OFF_LIMIT_A,
    ftpm_pkg::OFF_LIMIT_B, ftpm_pkg::OFF_STATUS, ftpm_pkg::OFF_MASK, 8'h40};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h50, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0,
    32'h0};

  ftpm_monitor #(.REF_HZ(REF)) i_ftpm_monitor
  (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tach_input_a(ta), .i_tach_input_b(tb_pin), .o_analog_sel(asel),
    .o_monitor_start(mstart), .o_irq(irq)
  );
  ftpm_fan_model i_fan_a (.i_period_ns(per_a), .o_tach(ta));
  ftpm_fan_model i_fan_b (.i_period_ns(per_b), .o_tach(tb_pin));

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Tach phase against the prescaler leaves up to two counts of slack
  task automatic near(input string what, input int exp, input logic [31:0] got);
    n_compared++;
    if (^got === 1'bx || got > exp + 2 || got + 2 < exp)
    begin
      num_errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic irq_is(input string what, input logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(what, exp, irq);
  endtask : irq_is

  // Two tach periods of reference ticks, each count worth 2^code reference ticks
  function automatic int exp_count(input int per, input int code);
    int c;
    c = (2 * per) / ((1_000_000_000 / REF) << code);
    return (c > 255) ? 255 : c;
  endfunction : exp_count

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin
    seed = 83127;
    cyc = 0;
    num_errors = 0;
    n_compared = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    per_a = 32'd20000;
    per_b = 32'd12000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      check("reset word", rv[i], rd);
      check("slave error", (i == 9), err);
    end
    apb(1'b1, ftpm_pkg::OFF_CONFIG, 32'h3);
    for (int c = 0; c < 4; c++)
    begin
      per_a <= 32'd8000 + ($random(seed) & 32'h3FFF);
      per_b <= 32'd8000 + ($random(seed) & 32'h3FFF);
      apb(1'b1, ftpm_pkg::OFF_VIDDIV, {24'h0, c[1:0], c[1:0], 4'h0});
      repeat (WAIT) @(posedge clk);
      apb(1'b0, ftpm_pkg::OFF_VALUE_A, 32'h0);
      near("count a", exp_count(per_a, c), rd);
      apb(1'b0, ftpm_pkg::OFF_VALUE_B, 32'h0);
      near("count b", exp_count(per_b, c), rd);
    end
    // Fan b far too slow: its count must stop at full scale, not wrap
    apb(1'b1, ftpm_pkg::OFF_VIDDIV, 32'h50);
    apb(1'b1, ftpm_pkg::OFF_LIMIT_B, 32'h80);
    per_b <= 32'd400000;
    repeat (17000) @(posedge clk);
    apb(1'b0, ftpm_pkg::OFF_VALUE_B, 32'h0);
    check("slow fan count", 32'hFF, rd);
    irq_is("irq on fail", 1'b1);
    apb(1'b1, ftpm_pkg::OFF_MASK, 32'h2);
    irq_is("irq masked", 1'b0);
    apb(1'b1, ftpm_pkg::OFF_MASK, 32'h0);
    irq_is("irq unmasked", 1'b1);
    apb(1'b0, ftpm_pkg::OFF_STATUS, 32'h0);
    check("fail status", 32'h2, rd);
    irq_is("irq after read", 1'b0);
    // Pin a as analog input: its value must freeze although the fan speeds up
    apb(1'b1, ftpm_pkg::OFF_CHMODE, 32'h1);
    repeat (2500) @(posedge clk);
    apb(1'b0, ftpm_pkg::OFF_VALUE_A, 32'h0);
    held = rd;
    per_a <= 32'd2000 + ($random(seed) & 32'h7FF);
    repeat (3000) @(posedge clk);
    apb(1'b0, ftpm_pkg::OFF_VALUE_A, 32'h0);
    check("value in analog mode", held, rd);
    apb(1'b1, ftpm_pkg::OFF_CHMODE, 32'h0);
    apb(1'b1, ftpm_pkg::OFF_CONFIG, 32'hB);
    @(negedge clk);
    check("start with clear", 1'b0, mstart);
    apb(1'b1, ftpm_pkg::OFF_CONFIG, 32'h0);
    apb(1'b0, ftpm_pkg::OFF_VALUE_A, 32'h0);
    held = rd;
    // A running monitor would now read about 100, outside every earlier value
    per_a <= 32'd40000;
    repeat (3000) @(posedge clk);
    apb(1'b0, ftpm_pkg::OFF_VALUE_A, 32'h0);
    check("value after stop", held, rd);
    apb(1'b1, ftpm_pkg::OFF_CHMODE, 32'h3);
    @(negedge clk);
    check("channel mode", 2'h3, asel);
    give_verdict();
  end
endmodule : tb_top
